// ### bench/link_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [5:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // immediate access: one-cycle strobe, read data taken one edge later
  task automatic access(input logic wr, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge i_mclk);
    #1;
    o_wr = wr;
    o_rd = !wr;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // idle bus shows inverted values so stale data never looks valid
    o_addr = ~a;
    o_wdata = ~d;
    q = i_rdata;
  endtask : access
endmodule : link_model
`default_nettype wire

// ### bench/ulpi_phy_vendor_detect_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_vendor_detect_regs_bench;
  import vendor_regs_pkg::*;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr, rd, id_fl, rise_en, fall_en, cmp_en, rid_en;
  logic       conv_end, value_rd, dp_seen, dm_seen, alt, done, cmp, hs_en;
  logic [5:0] addr, pads;
  logic [7:0] wdata, rdata;
  logic [1:0] lstate, squelch;
  logic [2:0] trim;
  int         failures, cmp_count, cycles, alt_seen;
  ulpi_phy_vendor_detect_regs ulpi_phy_vendor_detect_regs_inst (
    .i_mclk(mclk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_id_floating(id_fl), .i_id_float_rise_irq_en(rise_en),
    .i_id_float_fall_irq_en(fall_en), .i_charger_cmp_irq_en(cmp_en),
    .i_resistor_id_irq_en(rid_en), .i_resistor_id_conv_end(conv_end),
    .i_resistor_id_value_rd(value_rd), .i_dp_voltage_seen(dp_seen),
    .i_dm_voltage_seen(dm_seen), .i_linestate(lstate), .o_alt_int(alt),
    .o_resistor_id_done(done), .o_charger_cmp_out(cmp),
    .o_squelch_sensitivity(squelch), .o_tx_amplitude_trim(trim),
    .o_dp_voltage_source_en(pads[0]), .o_dm_voltage_source_en(pads[1]),
    .o_dp_current_sink_en(pads[2]), .o_dm_current_sink_en(pads[3]),
    .o_dp_contact_source_en(pads[4]), .o_dm_contact_source_en(pads[5]),
    .o_headset_audio_en(hs_en));
  link_model link_model_inst (.i_mclk(mclk), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (alt === 1'b1) alt_seen <= alt_seen + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    link_model_inst.access(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    link_model_inst.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rchk
  initial begin
    {id_fl, rise_en, fall_en, cmp_en, rid_en} = 5'h00;
    {conv_end, value_rd, dp_seen, dm_seen, lstate} = 6'h00;
    {failures, cmp_count, cycles, alt_seen} = '0;
    tick(16);
    rstn = 1'b1;
    rchk(ADDR_EVENT_LATCH, 8'h00);
    rchk(ADDR_HS_COMP, 8'h00);
    rchk(ADDR_CHARGER, 8'h00);
    rchk(ADDR_HEADSET, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wreg(ADDR_HS_COMP, {1'b1, i[2:0], 2'b11, i[1:0]});
      tick(1);
      check({6'h00, squelch}, {6'h00, i[1:0]});
      check({5'h00, trim}, {5'h00, i[2:0]});
      rchk(ADDR_HS_COMP, {1'b0, i[2:0], 2'b00, i[1:0]});
    end
    wreg(ADDR_CHARGER, 8'hf7);
    tick(1);
    check({2'b00, pads}, 8'h15);
    rchk(ADDR_CHARGER, 8'h07);
    wreg(ADDR_CHARGER, 8'h0f);
    tick(1);
    check({2'b00, pads}, 8'h2a);
    // host-port mode senses the minus line, so only dm_seen counts here
    cmp_en = 1'b1;
    dm_seen = 1'b1;
    tick(3);
    check({7'h00, cmp}, 8'h01);
    rchk(ADDR_CHARGER, 8'h1f);
    rchk(ADDR_EVENT_LATCH, 8'h02);
    rchk(ADDR_EVENT_LATCH, 8'h00);
    lstate = 2'b01;
    tick(3);
    check({7'h00, cmp}, 8'h00);
    lstate = 2'b00;
    tick(3);
    wreg(ADDR_CHARGER, 8'h08);
    tick(3);
    check({7'h00, cmp}, 8'h00);
    rchk(ADDR_EVENT_LATCH, 8'h02);
    rise_en = 1'b1;
    id_fl = 1'b1;
    tick(3);
    rchk(ADDR_EVENT_LATCH, 8'h01);
    id_fl = 1'b0;
    tick(3);
    rchk(ADDR_EVENT_LATCH, 8'h00);
    rise_en = 1'b0;
    fall_en = 1'b1;
    id_fl = 1'b1;
    tick(3);
    id_fl = 1'b0;
    tick(3);
    rchk(ADDR_EVENT_LATCH, 8'h01);
    rid_en = 1'b1;
    conv_end = 1'b1;
    tick(1);
    conv_end = 1'b0;
    tick(2);
    check({7'h00, done}, 8'h01);
    rchk(ADDR_EVENT_LATCH, 8'h08);
    value_rd = 1'b1;
    tick(1);
    value_rd = 1'b0;
    tick(2);
    check({7'h00, done}, 8'h00);
    check(alt_seen[7:0], 8'h07);
    wreg(ADDR_HEADSET, 8'hfa);
    tick(1);
    check({7'h00, hs_en}, 8'h01);
    rchk(ADDR_HEADSET, 8'h0a);
    wreg(ADDR_HEADSET, 8'h0b);
    tick(1);
    check({7'h00, hs_en}, 8'h00);
    // fall edge lands in the same cycle as the clearing read
    id_fl = 1'b1;
    tick(1);
    fork
      rchk(ADDR_EVENT_LATCH, 8'h00);
      begin
        @(posedge mclk);
        #1;
        id_fl = 1'b0;
      end
    join
    rchk(ADDR_EVENT_LATCH, 8'h01);
    wreg(ADDR_EVENT_LATCH, 8'hff);
    rchk(ADDR_EVENT_LATCH, 8'h00);
    wreg(ADDR_VENDOR_LO, 8'hff);
    rchk(ADDR_VENDOR_LO, 8'h00);
    rchk(ADDR_VENDOR_HI, 8'h00);
    wreg(ADDR_CHARGER, 8'h00);
    tick(1);
    check({2'b00, pads}, 8'h00);
    // mid-run reset must drop the written trim and squelch fields
    wreg(ADDR_HS_COMP, 8'h73);
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    rchk(ADDR_HS_COMP, 8'h00);
    check({6'h00, squelch}, 8'h00);
    check({5'h00, trim}, 8'h00);
    report_and_stop();
  end
endmodule : ulpi_phy_vendor_detect_regs_bench
`default_nettype wire

// ### hdl/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic last;
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      // follow the level in reset so a pin floating at release is no edge
      last <= i_level;
    end else begin
      last <= i_level;
    end
  end
  assign o_rise = i_level & ~last;
  assign o_fall = ~i_level & last;
endmodule : edge_detect
`default_nettype wire

// ### hdl/ulpi_phy_vendor_detect_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_vendor_detect_regs (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [5:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  output logic      [7:0]           o_reg_rdata,
  input  wire logic                 i_id_floating,
  input  wire logic                 i_id_float_rise_irq_en,
  input  wire logic                 i_id_float_fall_irq_en,
  input  wire logic                 i_charger_cmp_irq_en,
  input  wire logic                 i_resistor_id_irq_en,
  input  wire logic                 i_resistor_id_conv_end,
  input  wire logic                 i_resistor_id_value_rd,
  input  wire logic                 i_dp_voltage_seen,
  input  wire logic                 i_dm_voltage_seen,
  input  wire logic [1:0]           i_linestate,
  output logic                      o_alt_int,
  output logic                      o_resistor_id_done,
  output logic                      o_charger_cmp_out,
  output logic      [1:0]           o_squelch_sensitivity,
  output logic      [2:0]           o_tx_amplitude_trim,
  output logic                      o_dp_voltage_source_en,
  output logic                      o_dm_voltage_source_en,
  output logic                      o_dp_current_sink_en,
  output logic                      o_dm_current_sink_en,
  output logic                      o_dp_contact_source_en,
  output logic                      o_dm_contact_source_en,
  output logic                      o_headset_audio_en
);
  import vendor_regs_pkg::*;

  logic [7:0] hs_comp;
  logic [7:0] charger_ctrl;
  logic [7:0] headset_audio_key;
  logic [7:0] event_latch;
  logic       resistor_id_done;
  logic       charger_cmp_out;

  // only immediate accesses reach this port; vendor range decoded by address
  wire in_vendor   = (i_reg_addr >= ADDR_VENDOR_LO) &&
                     (i_reg_addr <= ADDR_VENDOR_HI);  // [RULE6]
  wire wr_hs       = i_reg_wr && in_vendor && (i_reg_addr == ADDR_HS_COMP);
  wire wr_charger  = i_reg_wr && in_vendor && (i_reg_addr == ADDR_CHARGER);
  wire wr_headset  = i_reg_wr && in_vendor && (i_reg_addr == ADDR_HEADSET);
  wire rd_latch    = i_reg_rd && (i_reg_addr == ADDR_EVENT_LATCH);  // [RULE4]

  wire host_port   = charger_ctrl[BIT_HOST_PORT];
  wire sink_en     = charger_ctrl[BIT_SINK_EN];
  // swapped sensing follows the host-port swap of the comparator
  wire sensed_line = host_port ? i_dm_voltage_seen : i_dp_voltage_seen;
  wire next_cmp    = sink_en && sensed_line &&
                     (i_linestate == LINESTATE_SE0);  // [RULE11]

  logic id_rise, id_fall, cmp_rise, cmp_fall, rid_rise;

  edge_detect id_edge (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_level(i_id_floating),
    .o_rise (id_rise),
    .o_fall (id_fall)
  );
  edge_detect cmp_edge (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_level(charger_cmp_out),
    .o_rise (cmp_rise),
    .o_fall (cmp_fall)
  );
  edge_detect rid_edge (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_level(resistor_id_done),
    .o_rise (rid_rise),
    .o_fall ()
  );

  wire ev_id  = (id_rise & i_id_float_rise_irq_en) |
                (id_fall & i_id_float_fall_irq_en);  // [RULE1]
  wire ev_cmp = (cmp_rise | cmp_fall) & i_charger_cmp_irq_en;  // [RULE2]
  wire ev_rid = rid_rise & i_resistor_id_irq_en;  // [RULE3]
  wire [7:0] new_events = {4'h0, ev_rid, 1'b0, ev_cmp, ev_id};
  // set wins over the read clear so a colliding event is not lost
  wire [7:0] next_latch = ((rd_latch ? RESET_VALUE : event_latch) |
                           new_events) & MASK_EVENT_LATCH;  // [RULE17] [RULE5]

  // done flag clears on a value read; a fresh conversion end wins
  wire next_done = i_resistor_id_conv_end |
                   (resistor_id_done & ~i_resistor_id_value_rd);  // [RULE16]

  wire [7:0] charger_view = (charger_ctrl & MASK_CHARGER_WR) |
                            ({7'h00, charger_cmp_out} << BIT_CMP_OUT);
  wire [7:0] read_mux =
      (i_reg_addr == ADDR_EVENT_LATCH) ? event_latch :
      (i_reg_addr == ADDR_HS_COMP)     ? hs_comp :
      (i_reg_addr == ADDR_CHARGER)     ? charger_view :  // [RULE12]
      (i_reg_addr == ADDR_HEADSET)     ? headset_audio_key :
                                         RESET_VALUE;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      hs_comp           <= RESET_VALUE;  // [RULE7]
      charger_ctrl      <= RESET_VALUE;
      headset_audio_key <= RESET_VALUE;  // [RULE14]
      event_latch       <= RESET_VALUE;
      resistor_id_done  <= 1'b0;
      charger_cmp_out   <= 1'b0;
      o_reg_rdata       <= RESET_VALUE;
    end else begin
      if (wr_hs) begin
        hs_comp <= i_reg_wdata & MASK_HS_COMP;  // [RULE18]
      end
      if (wr_charger) begin
        charger_ctrl <= i_reg_wdata & MASK_CHARGER_WR;  // [RULE9] [RULE18]
      end
      if (wr_headset) begin
        headset_audio_key <= i_reg_wdata & MASK_HEADSET;  // [RULE18]
      end
      event_latch      <= next_latch;
      resistor_id_done <= next_done;
      charger_cmp_out  <= next_cmp;
      if (i_reg_rd) begin
        o_reg_rdata <= read_mux;
      end
    end
  end

  // outputs registered from the control state
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_alt_int              <= 1'b0;
      o_resistor_id_done     <= 1'b0;
      o_charger_cmp_out      <= 1'b0;
      o_squelch_sensitivity  <= 2'h0;
      o_tx_amplitude_trim    <= 3'h0;
      o_dp_voltage_source_en <= 1'b0;
      o_dm_voltage_source_en <= 1'b0;
      o_dp_current_sink_en   <= 1'b0;
      o_dm_current_sink_en   <= 1'b0;
      o_dp_contact_source_en <= 1'b0;
      o_dm_contact_source_en <= 1'b0;
      o_headset_audio_en     <= 1'b0;
    end else begin
      // one pulse for each cycle with any enabled event, carried in the rxcmd alt_int field
      o_alt_int              <= |new_events;  // [RULE15]
      o_resistor_id_done     <= resistor_id_done;
      o_charger_cmp_out      <= charger_cmp_out;  // [RULE12]
      o_squelch_sensitivity  <= hs_comp[SQUELCH_MSB:SQUELCH_LSB];  // [RULE7]
      o_tx_amplitude_trim    <= hs_comp[TRIM_MSB:TRIM_LSB];  // [RULE8]
      o_dp_voltage_source_en <= charger_ctrl[BIT_SRC_EN] & ~host_port;
      o_dm_voltage_source_en <= charger_ctrl[BIT_SRC_EN] & host_port;
      o_dp_current_sink_en   <= sink_en & ~host_port;  // [RULE10]
      o_dm_current_sink_en   <= sink_en & host_port;
      o_dp_contact_source_en <= charger_ctrl[BIT_CONTACT_EN] & ~host_port;
      o_dm_contact_source_en <= charger_ctrl[BIT_CONTACT_EN] & host_port;
      o_headset_audio_en     <=
          (headset_audio_key[KEY_MSB:KEY_LSB] == HEADSET_KEY);  // [RULE14]
    end
  end

  chk_latch_read_clear : assert property (  // [RULE4]
    @(posedge i_mclk) disable iff (!i_rstn)
    rd_latch && new_events == 8'h00 |=> event_latch == 8'h00)
    else $error("event latch not cleared by read");
  chk_latch_set_wins : assert property (  // [RULE17]
    @(posedge i_mclk) disable iff (!i_rstn)
    rd_latch |=> (event_latch & $past(new_events)) == $past(new_events))
    else $error("event lost during clearing read");
  chk_latch_reserved : assert property (  // [RULE5]
    @(posedge i_mclk) disable iff (!i_rstn)
    (event_latch & ~MASK_EVENT_LATCH) == 8'h00)
    else $error("reserved latch bits set");
  chk_id_float_set : assert property (  // [RULE1]
    @(posedge i_mclk) disable iff (!i_rstn)
    ($rose(i_id_floating) && i_id_float_rise_irq_en) ||
      ($fell(i_id_floating) && i_id_float_fall_irq_en)
    |=> event_latch[BIT_ID_FLOAT])
    else $error("id float change not latched");
  chk_cmp_latch_set : assert property (  // [RULE2]
    @(posedge i_mclk) disable iff (!i_rstn)
    $changed(charger_cmp_out) && i_charger_cmp_irq_en
    |=> event_latch[BIT_CMP])
    else $error("comparator change not latched");
  chk_rid_latch_set : assert property (  // [RULE3]
    @(posedge i_mclk) disable iff (!i_rstn)
    $rose(resistor_id_done) && i_resistor_id_irq_en
    |=> event_latch[BIT_RID])
    else $error("conversion end not latched");
  chk_cmp_needs_sink : assert property (  // [RULE11]
    @(posedge i_mclk) disable iff (!i_rstn)
    !sink_en |=> !charger_cmp_out)
    else $error("comparator high while disabled");
  chk_cmp_linestate : assert property (  // [RULE11]
    @(posedge i_mclk) disable iff (!i_rstn)
    i_linestate != LINESTATE_SE0 |=> !charger_cmp_out)
    else $error("comparator high outside se0");
  chk_headset_key : assert property (  // [RULE14]
    @(posedge i_mclk) disable iff (!i_rstn)
    wr_headset |-> ##2 o_headset_audio_en ==
      ($past(i_reg_wdata[KEY_MSB:KEY_LSB], 2) == HEADSET_KEY))
    else $error("headset enable mismatch");
  chk_squelch_follows : assert property (  // [RULE7]
    @(posedge i_mclk) disable iff (!i_rstn)
    wr_hs |-> ##2 o_squelch_sensitivity ==
      $past(i_reg_wdata[SQUELCH_MSB:SQUELCH_LSB], 2))
    else $error("squelch field mismatch");
  chk_trim_follows : assert property (  // [RULE8]
    @(posedge i_mclk) disable iff (!i_rstn)
    wr_hs |-> ##2 o_tx_amplitude_trim ==
      $past(i_reg_wdata[TRIM_MSB:TRIM_LSB], 2))
    else $error("amplitude trim mismatch");
  chk_swap_routing : assert property (  // [RULE10]
    @(posedge i_mclk) disable iff (!i_rstn)
    host_port |=> !o_dp_voltage_source_en && !o_dp_current_sink_en &&
      !o_dp_contact_source_en)
    else $error("charger path not swapped to minus line");
  chk_alt_int_pulse : assert property (  // [RULE15]
    @(posedge i_mclk) disable iff (!i_rstn)
    ev_id || ev_cmp || ev_rid |=> o_alt_int)
    else $error("event without alt_int");
  chk_done_clears : assert property (  // [RULE16]
    @(posedge i_mclk) disable iff (!i_rstn)
    i_resistor_id_value_rd && !i_resistor_id_conv_end
    |=> !resistor_id_done)
    else $error("done flag not cleared by value read");
endmodule : ulpi_phy_vendor_detect_regs
`default_nettype wire

// ### hdl/vendor_regs_pkg.sv
// Summary of operation
// [RULE1] id float latch sets on enabled float rise or float fall change
// [RULE2] charger comparator latch sets on any comparator toggle when enabled
// [RULE3] resistor id latch sets on rising done flag when its enable is set
// [RULE4] event latch register is read only and clears after being read
// [RULE5] bit 2 and bits 7:4 of event latch always read zero
// [RULE6] vendor registers occupy 30h to 3Fh via immediate read and write
// [RULE7] squelch sensitivity bits 1:0 at 31h scale the threshold, reset 00
// [RULE8] transmit amplitude trim bits 6:4 raise hs swing, nominal at 000
// [RULE9] 32h bits enable voltage source, sink and comparator, contact source
// [RULE10] charging host port bit swaps dp and dm charger connections
// [RULE11] comparator status is 1 only if enabled, dp detected, linestate 00; with the host port bit set the code senses dm instead of dp
// [RULE12] same comparator result shown in charger and carkit status registers
// [RULE13] link should clear charger bits 2:0 before normal usb operation
// [RULE14] headset audio enabled only when 33h bits 3:0 equal 1010
// [RULE15] each enabled carkit event raises alt_int in the rxcmd byte
// [RULE16] resistor id done flag clears when link reads conversion value
// [RULE17] event arriving during clearing read stays latched
// [RULE18] reserved bits in 31h, 32h, 33h ignore writes, read zero
package vendor_regs_pkg;
  localparam logic [5:0] ADDR_EVENT_LATCH  = 6'h21;
  localparam logic [5:0] ADDR_HS_COMP      = 6'h31;
  localparam logic [5:0] ADDR_CHARGER      = 6'h32;
  localparam logic [5:0] ADDR_HEADSET      = 6'h33;
  localparam logic [5:0] ADDR_VENDOR_LO    = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI    = 6'h3f;
  localparam logic [7:0] MASK_EVENT_LATCH  = 8'h0b;
  localparam logic [7:0] MASK_HS_COMP      = 8'h73;
  localparam logic [7:0] MASK_CHARGER_WR   = 8'h0f;
  localparam logic [7:0] MASK_HEADSET      = 8'h0f;
  localparam logic [7:0] RESET_VALUE       = 8'h00;
  localparam logic [3:0] HEADSET_KEY       = 4'ha;
  localparam logic [1:0] LINESTATE_SE0     = 2'h0;
  localparam int         BIT_ID_FLOAT      = 0;
  localparam int         BIT_CMP           = 1;
  localparam int         BIT_RID           = 3;
  localparam int         BIT_SRC_EN        = 0;
  localparam int         BIT_SINK_EN       = 1;
  localparam int         BIT_CONTACT_EN    = 2;
  localparam int         BIT_HOST_PORT     = 3;
  localparam int         BIT_CMP_OUT       = 4;
  localparam int         SQUELCH_LSB       = 0;
  localparam int         SQUELCH_MSB       = 1;
  localparam int         TRIM_LSB          = 4;
  localparam int         TRIM_MSB          = 6;
  localparam int         KEY_LSB           = 0;
  localparam int         KEY_MSB           = 3;
endpackage : vendor_regs_pkg
